// [logic/supervision_timer_pkg.sv]
// constants and register map for the two-stage supervision timer
package supervision_timer_pkg;
    // clock and timeout range
    localparam longint unsigned CLK_HZ          = 40_000_000;
    localparam longint unsigned TIMEOUT_MIN_MS  = 1;
    localparam longint unsigned TIMEOUT_MAX_MIN = 10;
    localparam int              CNT_W           = 35;
    // least time rounds up, longest time rounds down
    localparam logic [34:0] TIMEOUT_MIN_CYC =
        35'((CLK_HZ * TIMEOUT_MIN_MS + 999) / 1000);
    localparam logic [34:0] TIMEOUT_MAX_CYC =
        35'(CLK_HZ * TIMEOUT_MAX_MIN * 60);
    localparam logic [7:0]  RESET_PULSE_CYC = 8'h10;

    // register byte offsets
    localparam logic [7:0] CTRL_OFS       = 8'h00;
    localparam logic [7:0] PRELOAD1_LO_OFS = 8'h04;
    localparam logic [7:0] PRELOAD1_HI_OFS = 8'h08;
    localparam logic [7:0] PRELOAD2_LO_OFS = 8'h0C;
    localparam logic [7:0] PRELOAD2_HI_OFS = 8'h10;
    localparam logic [7:0] RELOAD_OFS     = 8'h14;
    localparam logic [7:0] STATUS_OFS     = 8'h18;
    localparam logic [7:0] COUNT_LO_OFS   = 8'h1C;
    localparam logic [7:0] COUNT_HI_OFS   = 8'h20;

    // control fields
    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_SEL_LSB   = 1;
    localparam int CTRL_RSTEN_BIT = 3;
    // status fields
    localparam int STAT_STAGE2_BIT = 0;
    localparam int STAT_TO1_BIT    = 1;
    localparam int STAT_RST_BIT    = 2;

    // reset values
    localparam logic [3:0]  CTRL_RST     = 4'h8;
    localparam logic [34:0] PRELOAD_RST  = 35'h0_0000_9C40;

    // delivery of the first-stage expiry
    typedef enum logic [1:0] {
        SEL_IRQ = 2'b00,
        SEL_MGMT = 2'b01,
        SEL_PWR  = 2'b10,
        SEL_OFF = 2'b11
    } irq_sel_t;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_STAGE1 = 2'b01,
        ST_STAGE2 = 2'b10,
        ST_RESET  = 2'b11
    } wd_state_t;
endpackage : supervision_timer_pkg

// [logic/down_counter35.sv]
// loadable 35-bit down-counter that stops at zero
`timescale 1ns/1ps
`default_nettype none
module down_counter35 (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // control
    input  wire logic        load,
    input  wire logic [34:0] load_val,
    input  wire logic        run,
    // state
    output logic      [34:0] count,
    output logic             at_zero
);
    logic [34:0] count_r;

    assign count   = count_r;
    assign at_zero = (count_r == 35'h0_0000_0000);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= 35'h0_0000_0000;
        end else if (load) begin
            count_r <= load_val;
        end else if (run && !at_zero) begin
            count_r <= count_r - 35'h0_0000_0001;
        end
    end
endmodule : down_counter35
`default_nettype wire

// [logic/two_stage_watchdog_timer.sv]
// two-stage supervision timer with APB register access
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - 35-bit down-counter loads preload one, counts
// - first-stage zero without reload raises interrupt
// - then load preload two, count second stage
// - second-stage expiry asserts hard system reset
// - expiry routed to irq, management or power
// - timeouts span one millisecond to ten minutes
module two_stage_watchdog_timer #(
    parameter logic [34:0] MIN_TIMEOUT_CYC = supervision_timer_pkg::TIMEOUT_MIN_CYC,
    parameter logic [34:0] MAX_TIMEOUT_CYC = supervision_timer_pkg::TIMEOUT_MAX_CYC
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // expiry and reset outputs
    output logic             irq_req,
    output logic             system_management_interrupt,
    output logic             power_event_interrupt,
    output logic             sys_reset
);
    // register state
    logic [3:0]  ctrl_r;
    logic [34:0] preload1_r;
    logic [34:0] preload2_r;
    logic        to1_flag_r;
    logic        rst_flag_r;
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    logic        irq_r;
    logic        mgmt_r;
    logic        pwr_r;
    logic        sys_reset_r;
    logic [7:0]  pulse_cnt_r;
    supervision_timer_pkg::wd_state_t state_r;
    supervision_timer_pkg::wd_state_t state_nxt;

    // bus decode
    wire access   = psel && penable;
    wire do_write = access && pready_r && pwrite;
    wire hit_ctrl = (paddr == supervision_timer_pkg::CTRL_OFS);
    wire hit_p1lo = (paddr == supervision_timer_pkg::PRELOAD1_LO_OFS);
    wire hit_p1hi = (paddr == supervision_timer_pkg::PRELOAD1_HI_OFS);
    wire hit_p2lo = (paddr == supervision_timer_pkg::PRELOAD2_LO_OFS);
    wire hit_p2hi = (paddr == supervision_timer_pkg::PRELOAD2_HI_OFS);
    wire hit_rld  = (paddr == supervision_timer_pkg::RELOAD_OFS);
    wire hit_stat = (paddr == supervision_timer_pkg::STATUS_OFS);
    wire hit_cnlo = (paddr == supervision_timer_pkg::COUNT_LO_OFS);
    wire hit_cnhi = (paddr == supervision_timer_pkg::COUNT_HI_OFS);
    wire mapped   = hit_ctrl | hit_p1lo | hit_p1hi | hit_p2lo | hit_p2hi |
                    hit_rld | hit_stat | hit_cnlo | hit_cnhi;
    wire wr_ok    = do_write && mapped;

    // control fields
    wire enable  = ctrl_r[supervision_timer_pkg::CTRL_EN_BIT];
    wire rst_en  = ctrl_r[supervision_timer_pkg::CTRL_RSTEN_BIT];
    wire [1:0] sel_bits = ctrl_r[supervision_timer_pkg::CTRL_SEL_LSB +: 2];
    wire reload_wr = wr_ok && hit_rld;

    // timeout held inside the supported range
    wire [34:0] p1_eff = (preload1_r < MIN_TIMEOUT_CYC) ? MIN_TIMEOUT_CYC :
                         (preload1_r > MAX_TIMEOUT_CYC) ? MAX_TIMEOUT_CYC : preload1_r;
    wire [34:0] p2_eff = (preload2_r < MIN_TIMEOUT_CYC) ? MIN_TIMEOUT_CYC :
                         (preload2_r > MAX_TIMEOUT_CYC) ? MAX_TIMEOUT_CYC : preload2_r;

    // counter
    wire [34:0] count;
    wire        at_zero;
    wire in_stage1 = (state_r == supervision_timer_pkg::ST_STAGE1);
    wire in_stage2 = (state_r == supervision_timer_pkg::ST_STAGE2);
    wire start     = (state_r == supervision_timer_pkg::ST_IDLE) && enable;
    wire expire1   = in_stage1 && at_zero && !reload_wr;
    wire expire2   = in_stage2 && at_zero && !reload_wr;
    wire refresh   = (in_stage1 || in_stage2) && reload_wr;
    wire cnt_load  = start || refresh || expire1;
    wire [34:0] cnt_val = expire1 ? p2_eff : p1_eff;

    down_counter35 u_counter (
        .pclk     (pclk),
        .presetn  (presetn),
        .load     (cnt_load),
        .load_val (cnt_val),
        .run      (in_stage1 || in_stage2),
        .count    (count),
        .at_zero  (at_zero)
    );

    // stage sequencing
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            supervision_timer_pkg::ST_IDLE: begin
                if (enable) begin
                    state_nxt = supervision_timer_pkg::ST_STAGE1;
                end
            end
            supervision_timer_pkg::ST_STAGE1: begin
                if (!enable) begin
                    state_nxt = supervision_timer_pkg::ST_IDLE;
                end else if (expire1) begin
                    state_nxt = supervision_timer_pkg::ST_STAGE2;
                end
            end
            supervision_timer_pkg::ST_STAGE2: begin
                if (!enable) begin
                    state_nxt = supervision_timer_pkg::ST_IDLE;
                end else if (refresh) begin
                    state_nxt = supervision_timer_pkg::ST_STAGE1;
                end else if (expire2) begin
                    state_nxt = supervision_timer_pkg::ST_RESET;
                end
            end
            supervision_timer_pkg::ST_RESET: begin
                if (pulse_cnt_r == 8'h01) begin
                    state_nxt = supervision_timer_pkg::ST_IDLE;
                end
            end
        endcase
    end

    // read mux
    wire [31:0] status_word = {29'h0, rst_flag_r, to1_flag_r, in_stage2};
    wire [31:0] rd_data =
        hit_ctrl ? {28'h0, ctrl_r} :
        hit_p1lo ? preload1_r[31:0] :
        hit_p1hi ? {29'h0, preload1_r[34:32]} :
        hit_p2lo ? preload2_r[31:0] :
        hit_p2hi ? {29'h0, preload2_r[34:32]} :
        hit_stat ? status_word :
        hit_cnlo ? count[31:0] :
        hit_cnhi ? {29'h0, count[34:32]} : 32'h0000_0000;

    // expiry routing
    wire route_irq = expire1 && (sel_bits == supervision_timer_pkg::SEL_IRQ);
    wire route_mgmt = expire1 && (sel_bits == supervision_timer_pkg::SEL_MGMT);
    wire route_pwr  = expire1 && (sel_bits == supervision_timer_pkg::SEL_PWR);
    wire clr_to1   = wr_ok && hit_stat && pwdata[supervision_timer_pkg::STAT_TO1_BIT];
    wire clr_rst   = wr_ok && hit_stat && pwdata[supervision_timer_pkg::STAT_RST_BIT];
    wire fire_rst  = expire2 && enable && rst_en;
    wire ctrl_clr  = expire2 && enable;

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;
    assign irq_req = irq_r;
    assign system_management_interrupt = mgmt_r;
    assign power_event_interrupt       = pwr_r;
    assign sys_reset = sys_reset_r;

    // apb answer: one wait state, then pready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= access && !pready_r;
            pslverr_r <= access && !pready_r && !mapped;
            prdata_r  <= (access && !pready_r && !pwrite) ? rd_data : 32'h0000_0000;
        end
    end

    // software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r     <= supervision_timer_pkg::CTRL_RST;
            preload1_r <= supervision_timer_pkg::PRELOAD_RST;
            preload2_r <= supervision_timer_pkg::PRELOAD_RST;
        end else begin
            if (ctrl_clr) begin
                ctrl_r[supervision_timer_pkg::CTRL_EN_BIT] <= 1'b0;
            end else if (wr_ok && hit_ctrl) begin
                ctrl_r <= pwdata[3:0];
            end
            if (wr_ok && hit_p1lo) preload1_r[31:0]  <= pwdata;
            if (wr_ok && hit_p1hi) preload1_r[34:32] <= pwdata[2:0];
            if (wr_ok && hit_p2lo) preload2_r[31:0]  <= pwdata;
            if (wr_ok && hit_p2hi) preload2_r[34:32] <= pwdata[2:0];
        end
    end

    // sticky flags: a new event beats a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            to1_flag_r <= 1'b0;
            rst_flag_r <= 1'b0;
        end else begin
            to1_flag_r <= expire1 | (to1_flag_r & ~clr_to1);
            rst_flag_r <= fire_rst | (rst_flag_r & ~clr_rst);
        end
    end

    // outputs and reset pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r     <= supervision_timer_pkg::ST_IDLE;
            irq_r       <= 1'b0;
            mgmt_r      <= 1'b0;
            pwr_r       <= 1'b0;
            sys_reset_r <= 1'b0;
            pulse_cnt_r <= 8'h00;
        end else begin
            state_r     <= state_nxt;
            irq_r       <= route_irq;
            mgmt_r      <= route_mgmt;
            pwr_r       <= route_pwr;
            if (fire_rst) begin
                sys_reset_r <= 1'b1;
                pulse_cnt_r <= supervision_timer_pkg::RESET_PULSE_CYC;
            end else if (pulse_cnt_r != 8'h00) begin
                pulse_cnt_r <= pulse_cnt_r - 8'h01;
                sys_reset_r <= (pulse_cnt_r != 8'h01);
            end else begin
                sys_reset_r <= 1'b0;
            end
        end
    end
endmodule : two_stage_watchdog_timer
`default_nettype wire

// [tb/supervision_timer_props.sv]
// port assertions for the two-stage supervision timer
`timescale 1ns/1ps
`default_nettype none
module supervision_timer_props (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // outputs
    input wire logic        irq_req,
    input wire logic        system_management_interrupt,
    input wire logic        power_event_interrupt,
    input wire logic        sys_reset
);
    wire logic any_int = irq_req | system_management_interrupt | power_event_interrupt;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_rdy_wait; psel && penable && !pready |=> pready; endproperty
    a_rdy_wait: assert property (p_rdy_wait) else $error("pready late");
    property p_rdy_pulse; pready |=> !pready; endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready too long");
    property p_err_rdy; pslverr |-> pready; endproperty
    a_err_rdy: assert property (p_err_rdy) else $error("pslverr without pready");
    property p_rdata_idle; !pready |-> prdata == 32'h0; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not idle");
    property p_int_one; $onehot0({irq_req, system_management_interrupt, power_event_interrupt}); endproperty
    a_int_one: assert property (p_int_one) else $error("two expiry outputs");
    property p_int_pulse; any_int |=> !any_int; endproperty
    a_int_pulse: assert property (p_int_pulse) else $error("expiry pulse too long");
    property p_stage2_min; any_int |-> !sys_reset [*8]; endproperty
    a_stage2_min: assert property (p_stage2_min) else $error("second stage too short");
    property p_rst_len; $rose(sys_reset) |-> sys_reset [*8] ##1 sys_reset [*8] ##1 !sys_reset; endproperty
    a_rst_len: assert property (p_rst_len) else $error("reset pulse length");
endmodule : supervision_timer_props
bind two_stage_watchdog_timer supervision_timer_props chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_req(irq_req),
    .system_management_interrupt(system_management_interrupt),
    .power_event_interrupt(power_event_interrupt), .sys_reset(sys_reset));
`default_nettype wire

// [tb/reset_sink_model.sv]
// system reset logic model measuring reset pulse width
`timescale 1ns/1ps
`default_nettype none
module reset_sink_model (
    input  wire logic pclk,
    input  wire logic sys_reset,
    output var  int   width
);
    int run = 0;
    always @(posedge pclk) begin
        if (sys_reset) run <= run + 1;
        else if (run != 0) begin
            width <= run;
            run   <= 0;
        end
    end
endmodule : reset_sink_model
`default_nettype wire

// [tb/tb_two_stage_watchdog_timer.sv]
// self-checking bench for the two-stage supervision timer
`timescale 1ns/1ps
`default_nettype none
module tb_two_stage_watchdog_timer;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, irq_req, mgmt_int, pei, sys_reset;
    logic [3:0] ev_prev = 4'h0;
    wire logic [3:0] ev_now = {sys_reset, pei, mgmt_int, irq_req};
    logic [33:0] q[$], e;
    logic [3:0] ev_q[$];
    int num_errors = 0, checked = 0, ev_n = 0, p1, p2, pe;
    int rst_width;
    two_stage_watchdog_timer #(.MIN_TIMEOUT_CYC(35'h8), .MAX_TIMEOUT_CYC(35'hC8)) dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_req(irq_req),
        .system_management_interrupt(mgmt_int), .power_event_interrupt(pei), .sys_reset(sys_reset));
    reset_sink_model sink (.pclk(pclk), .sys_reset(sys_reset), .width(rst_width));
    always #12.5 pclk = ~pclk;
    task check(input logic [33:0] s, input logic [33:0] x);
        checked++;
        if (s !== x) begin
            num_errors++;
            $display("Error at %0t: got %h want %h", $time, s, x);
        end
    endtask : check
    task results;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : results
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] x);
        q.push_back(x);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        {psel, penable} <= 2'b00;
    endtask : apb
    task wr(input logic [7:0] a, input int d);
        apb(1, a, 32'(d), 34'h0);
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] x);
        apb(0, a, 32'h0, {2'b10, x});
    endtask : rd
    task wait_ev(input int lo, input int hi);
        int c0, n;
        c0 = ev_n;
        n = 0;
        while (ev_n == c0 && n < 1000) begin
            @(posedge pclk);
            n++;
        end
        check(34'(n >= lo && n <= hi), 34'h1);
    endtask : wait_ev
    always @(posedge pclk) begin
        ev_prev <= ev_now;
        if (pready === 1'b1) begin
            e = q.pop_front();
            check(34'(pslverr), 34'(e[32]));
            if (e[33]) check(34'(prdata), 34'(e[31:0]));
        end
        if ((ev_now & ~ev_prev) != 4'h0) begin
            ev_n <= ev_n + 1;
            check(34'(ev_now & ~ev_prev), 34'(ev_q.pop_front()));
        end
    end
    initial begin
        #200_000;
        num_errors++;
        results;
    end
    initial begin
        void'($urandom(14));
        repeat (16) @(posedge pclk);
        presetn <= 1;
        rd(supervision_timer_pkg::CTRL_OFS, 32'h8);
        rd(supervision_timer_pkg::PRELOAD1_LO_OFS, 32'h9C40);
        rd(supervision_timer_pkg::STATUS_OFS, 32'h0);
        apb(0, 8'h24, 32'h0, {2'b11, 32'h0});
        wr(supervision_timer_pkg::COUNT_LO_OFS, 5);
        rd(supervision_timer_pkg::COUNT_LO_OFS, 32'h0);
        for (int s = 0; s < 3; s++) begin
            p1 = (s == 0) ? 1 : 10 + $urandom % 30;
            p2 = 20 + $urandom % 20;
            pe = (p1 < 8) ? 8 : p1;
            wr(supervision_timer_pkg::PRELOAD1_LO_OFS, p1);
            wr(supervision_timer_pkg::PRELOAD2_LO_OFS, p2);
            ev_q.push_back(4'(1 << s));
            wr(supervision_timer_pkg::CTRL_OFS, s * 2 + 1);
            wait_ev(pe, pe + 8);
            rd(supervision_timer_pkg::STATUS_OFS, 32'h3);
            wr(supervision_timer_pkg::STATUS_OFS, 2);
            rd(supervision_timer_pkg::STATUS_OFS, 32'h1);
            wr(supervision_timer_pkg::RELOAD_OFS, 0);
            rd(supervision_timer_pkg::STATUS_OFS, 32'h0);
            ev_q.push_back(4'(1 << s));
            wait_ev(pe - 4, pe + 8);
            wr(supervision_timer_pkg::CTRL_OFS, 0);
        end
        wr(supervision_timer_pkg::CTRL_OFS, 1);
        repeat (5) begin
            repeat (pe - 8) @(posedge pclk);
            wr(supervision_timer_pkg::RELOAD_OFS, 0);
        end
        wr(supervision_timer_pkg::CTRL_OFS, 0);
        wr(supervision_timer_pkg::STATUS_OFS, 2);
        wr(supervision_timer_pkg::CTRL_OFS, 7);
        repeat (pe + 8) @(posedge pclk);
        rd(supervision_timer_pkg::STATUS_OFS, 32'h3);
        wr(supervision_timer_pkg::CTRL_OFS, 0);
        check(34'(ev_q.size()), 34'h0);
        wr(supervision_timer_pkg::PRELOAD1_HI_OFS, 1);
        ev_q.push_back(4'h1);
        ev_q.push_back(4'h8);
        wr(supervision_timer_pkg::CTRL_OFS, 9);
        wait_ev(200, 208);
        wait_ev(p2, p2 + 8);
        repeat (24) @(posedge pclk);
        check(34'(rst_width), 34'd16);
        rd(supervision_timer_pkg::CTRL_OFS, 32'h8);
        rd(supervision_timer_pkg::STATUS_OFS, 32'h6);
        repeat (4) @(posedge pclk);
        results;
    end
endmodule : tb_two_stage_watchdog_timer
`default_nettype wire
